// [hw/indicator_cfg.svh]
/*
  Offsets, field positions, reset values and timing figures of the scanner
  status indicator. Assumes a 40 MHz system clock.
*/
`ifndef INDICATOR_CFG_SVH
`define INDICATOR_CFG_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CFG_CLK_PERIOD_NS  25
`define CFG_HALF_SEC_NS    500000000
`define CFG_HALF_SEC_CYC   (`CFG_HALF_SEC_NS / `CFG_CLK_PERIOD_NS)
`define CFG_AUTOCLR_S      10
`define CFG_FREE_S         5
`define CFG_BOOT_STEP_S    2
`define CFG_PING_STEP_S    2

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CFG_REG_CTRL       4'h0
`define CFG_REG_STATE      4'h4
`define CFG_REG_IRQ_STAT   4'h8
`define CFG_REG_IRQ_MASK   4'hC

// ----------------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------------
`define CFG_CTRL_DISP_ON   0
`define CFG_CTRL_QUAD      1
`define CFG_CTRL_RESET     2'h1
`define CFG_IRQ_W          4
`define CFG_IRQ_ERR        0
`define CFG_IRQ_AUTOCLR    1
`define CFG_IRQ_PING       2
`define CFG_IRQ_LOADED     3
`define CFG_MASK_RESET     4'h0

`endif

// [hw/indicator_pkg.sv]
/*
  Types shared by the scanner status indicator and its surroundings.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package indicator_pkg;

  typedef enum logic [3:0] {
    ST_BOOT   = 4'h0,
    ST_LEVEL  = 4'h1,
    ST_NORMAL = 4'h3,
    ST_MSG    = 4'h2,
    ST_WAIT   = 4'h6,
    ST_LOAD   = 4'h7,
    ST_PING   = 4'h5
  } disp_state_type;

  typedef enum logic [4:0] {
    TXT_BLANK, TXT_TYPE, TXT_VERSION, TXT_SERIAL, TXT_NAME, TXT_IP_MODE,
    TXT_WIRELESS, TXT_SETUP_REQUIRED, TXT_LEVEL, TXT_CFG_DATE, TXT_SIGNATURE,
    TXT_FIELD_PAIR, TXT_SETUP_WAIT, TXT_DOWNLOAD, TXT_PING, TXT_DEVICE_NAME,
    TXT_MESSAGE
  } text_type;

  typedef enum logic [2:0] {
    CAT_FAILURE, CAT_EXTERNAL, CAT_USAGE, CAT_INFO, CAT_PARAMETER
  } category_type;

  typedef struct packed {
    logic powered;
    logic safety_output_pair_on;
    logic restart_interlock_on;
    logic restart_interlock_ready;
    logic protect_occupied;
    logic warn_occupied;
    logic warn2_occupied;
    logic warn3_occupied;
    logic linked_enabled;
    logic has_config;
    logic boot_done;
    logic setup_wait;
    logic setup_confirmed;
    logic setup_done;
    logic ping;
  } scan_state_type;

  typedef struct packed {
    logic         valid;
    logic         locking;
    logic         from_device;
    category_type category;
    logic [11:0]  code;
  } error_in_type;

  typedef struct packed {
    logic led1_red;
    logic led1_green;
    logic led2;
    logic led3;
    logic led4;
    logic led5;
    logic led6_red;
  } led_type;

  typedef struct packed {
    logic        enabled;
    text_type    text;
    logic        from_device;
    logic [7:0]  letter;
    logic [11:0] code;
  } display_type;

endpackage

// [hw/status_indicator.sv]
/*
  Scanner status indicator: six LEDs, text display sequencing, error
  display with timed clearing, Avalon-MM register slave with interrupt.
  Assumes scanner state and error reports arrive from logic on the same
  clock; the display driver renders the text selector with its own data.
*/
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "indicator_cfg.svh"

// Operation
// - six LEDs, first three for protective function
// - LED 2 steady ready interlock, flashing occupied
// - LED 2 steady when free and linked enabled
// - four-field: LED 4 follows warning field 3
// - four-field: LED 5 flashes on field 2
// - normal display shows monitored field pair
// - unconfigured boot cycle then level display
// - configured boot cycle then field pair
// - wait text until confirmed, then download text
// - ping shows ping text then device name
// - messages carry source and error code
// - category letters F E U I P
// - letter first, then numeric code
// - non-locking errors clear after ten seconds
// - locking errors hold until power cycle
// - free field five seconds restores normal display
module status_indicator #(
  parameter int unsigned HALF_SEC_CYC = `CFG_HALF_SEC_CYC
) (
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  input  wire indicator_pkg::scan_state_type scan,
  input  wire indicator_pkg::error_in_type   err_in,
  input  wire logic [3:0]                    address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [31:0]                   writedata,
  output logic [31:0]                        readdata,
  output logic                               waitrequest,
  output indicator_pkg::led_type             leds,
  output indicator_pkg::display_type         display,
  output logic                               irq
);

  localparam int unsigned HALF_W = $clog2(HALF_SEC_CYC + 1);
  localparam logic [4:0] AUTOCLR_HALVES = 5'(2 * `CFG_AUTOCLR_S);
  localparam logic [4:0] FREE_HALVES    = 5'(2 * `CFG_FREE_S);
  localparam logic [4:0] BOOT_HALVES    = 5'(2 * `CFG_BOOT_STEP_S);
  localparam logic [4:0] PING_HALVES    = 5'(2 * `CFG_PING_STEP_S);

  // elaboration-time refusal: the flash phase needs a counter of two states or more
  if (HALF_SEC_CYC < 2) begin : g_bad_half
    $error("HALF_SEC_CYC must be at least 2");
  end

  function automatic logic [7:0] cat_letter(input indicator_pkg::category_type c);
    case (c)
      indicator_pkg::CAT_FAILURE:   cat_letter = 8'h46;
      indicator_pkg::CAT_EXTERNAL:  cat_letter = 8'h45;
      indicator_pkg::CAT_USAGE:     cat_letter = 8'h55;
      indicator_pkg::CAT_INFO:      cat_letter = 8'h49;
      indicator_pkg::CAT_PARAMETER: cat_letter = 8'h50;
      default:                      cat_letter = 8'h3F;
    endcase
  endfunction

  function automatic logic [4:0] count_up(input logic [4:0] c, input logic [4:0] lim);
    count_up = (c == lim) ? c : c + 5'h01;
  endfunction

  // ----------------------------------------------------------------------
  // half-second timebase and flash phase
  // ----------------------------------------------------------------------
  logic [HALF_W-1:0] half_cnt;
  logic [HALF_W-1:0] next_half_cnt;
  logic              half_tick;
  logic              flash;
  logic              next_flash;

  always_comb begin
    half_tick     = (half_cnt == HALF_W'(HALF_SEC_CYC - 1));
    next_half_cnt = half_tick ? '0 : half_cnt + HALF_W'(1);
    next_flash    = half_tick ? ~flash : flash;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      half_cnt <= '0;
      flash    <= 1'b0;
    end else begin
      half_cnt <= next_half_cnt;
      flash    <= next_flash;
    end
  end

  // ----------------------------------------------------------------------
  // error latch and automatic clear
  // ----------------------------------------------------------------------
  logic        err_active;
  logic        err_lock;
  logic        err_src;
  logic [7:0]  err_letter;
  logic [11:0] err_code;
  logic [4:0]  clr_cnt;
  logic        next_err_active;
  logic        next_err_lock;
  logic        next_err_src;
  logic [7:0]  next_err_letter;
  logic [11:0] next_err_code;
  logic [4:0]  next_clr_cnt;
  logic        auto_clear;

  always_comb begin
    next_err_active = err_active;
    next_err_lock   = err_lock;
    next_err_src    = err_src;
    next_err_letter = err_letter;
    next_err_code   = err_code;
    next_clr_cnt    = clr_cnt;
    auto_clear      = 1'b0;
    if (err_in.valid && !err_lock) begin
      next_err_active = 1'b1;
      next_err_lock   = err_in.locking;
      next_err_src    = err_in.from_device;
      next_err_letter = cat_letter(err_in.category);
      next_err_code   = err_in.code;
      next_clr_cnt    = '0;
    end else if (err_active && !err_lock) begin
      if (half_tick) begin
        next_clr_cnt = count_up(clr_cnt, AUTOCLR_HALVES);
      end
      // the clear only drops the report; the interlock stays with the scanner
      if (clr_cnt == AUTOCLR_HALVES) begin
        next_err_active = 1'b0;
        next_clr_cnt    = '0;
        auto_clear      = 1'b1;
      end
    end else if (!err_active) begin
      next_clr_cnt = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      err_active <= 1'b0;
      err_lock   <= 1'b0;
      err_src    <= 1'b0;
      err_letter <= 8'h00;
      err_code   <= 12'h000;
      clr_cnt    <= '0;
    end else begin
      err_active <= next_err_active;
      err_lock   <= next_err_lock;
      err_src    <= next_err_src;
      err_letter <= next_err_letter;
      err_code   <= next_err_code;
      clr_cnt    <= next_clr_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // field-free interval
  // ----------------------------------------------------------------------
  logic [4:0] free_cnt;
  logic [4:0] next_free_cnt;
  logic       free_long;

  always_comb begin
    if (scan.protect_occupied || err_active) begin
      next_free_cnt = '0;
    end else if (half_tick) begin
      next_free_cnt = count_up(free_cnt, FREE_HALVES);
    end else begin
      next_free_cnt = free_cnt;
    end
    free_long = (free_cnt == FREE_HALVES);
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      free_cnt <= '0;
    end else begin
      free_cnt <= next_free_cnt;
    end
  end

  // ----------------------------------------------------------------------
  // display sequencer
  // ----------------------------------------------------------------------
  indicator_pkg::disp_state_type state;
  indicator_pkg::disp_state_type next_state;
  logic [3:0] step;
  logic [3:0] next_step;
  logic [4:0] dwell;
  logic [4:0] next_dwell;
  logic       step_due;
  logic [3:0] last_step;
  logic       ping_seen;
  logic       loaded_evt;

  always_comb begin
    last_step = scan.has_config ? 4'h8 : 4'h6;
    step_due  = half_tick && (dwell == BOOT_HALVES - 5'h01);
    next_state = state;
    next_step  = step;
    next_dwell = half_tick ? dwell + 5'h01 : dwell;
    if (step_due) begin
      next_dwell = '0;
    end
    ping_seen  = 1'b0;
    loaded_evt = 1'b0;
    case (state)
      indicator_pkg::ST_BOOT: begin
        if (scan.boot_done) begin
          next_state = scan.has_config ? indicator_pkg::ST_NORMAL
                                       : indicator_pkg::ST_LEVEL;
          next_dwell = '0;
        end else if (step_due) begin
          next_step = (step >= last_step) ? 4'h0 : step + 4'h1;
        end
      end
      indicator_pkg::ST_LEVEL: begin
        next_step = 4'h0;
      end
      indicator_pkg::ST_NORMAL: begin
        if (err_active) begin
          next_state = indicator_pkg::ST_MSG;
        end
      end
      indicator_pkg::ST_MSG: begin
        if (free_long) begin
          next_state = indicator_pkg::ST_NORMAL;
        end
      end
      indicator_pkg::ST_WAIT: begin
        if (scan.setup_confirmed) begin
          next_state = indicator_pkg::ST_LOAD;
        end
      end
      indicator_pkg::ST_LOAD: begin
        if (scan.setup_done) begin
          next_state = indicator_pkg::ST_NORMAL;
          loaded_evt = 1'b1;
        end
      end
      indicator_pkg::ST_PING: begin
        if (half_tick && dwell == PING_HALVES - 5'h01) begin
          next_dwell = '0;
          if (step == 4'h1) begin
            next_state = indicator_pkg::ST_NORMAL;
            next_step  = 4'h0;
          end else begin
            next_step = 4'h1;
          end
        end
      end
      default: begin
        next_state = indicator_pkg::ST_BOOT;
        next_step  = 4'h0;
      end
    endcase
    // transfer and identification take over the display from any state except boot
    if (state != indicator_pkg::ST_BOOT) begin
      if (scan.setup_wait && state != indicator_pkg::ST_LOAD) begin
        next_state = indicator_pkg::ST_WAIT;
      end else if (scan.ping && state != indicator_pkg::ST_PING) begin
        next_state = indicator_pkg::ST_PING;
        next_step  = 4'h0;
        next_dwell = '0;
        ping_seen  = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= indicator_pkg::ST_BOOT;
      step  <= 4'h0;
      dwell <= '0;
    end else begin
      state <= next_state;
      step  <= next_step;
      dwell <= next_dwell;
    end
  end

  // ----------------------------------------------------------------------
  // text selection
  // ----------------------------------------------------------------------
  indicator_pkg::text_type text;

  always_comb begin
    text = indicator_pkg::TXT_BLANK;
    case (state)
      indicator_pkg::ST_BOOT: begin
        case (step)
          4'h0:    text = indicator_pkg::TXT_TYPE;
          4'h1:    text = indicator_pkg::TXT_VERSION;
          4'h2:    text = indicator_pkg::TXT_SERIAL;
          4'h3:    text = indicator_pkg::TXT_NAME;
          4'h4:    text = indicator_pkg::TXT_IP_MODE;
          4'h5:    text = indicator_pkg::TXT_WIRELESS;
          4'h6:    text = scan.has_config ? indicator_pkg::TXT_CFG_DATE
                                          : indicator_pkg::TXT_SETUP_REQUIRED;
          4'h7:    text = indicator_pkg::TXT_SIGNATURE;
          // configured boot closes its round with the level reading
          default: text = indicator_pkg::TXT_LEVEL;
        endcase
      end
      indicator_pkg::ST_LEVEL:  text = indicator_pkg::TXT_LEVEL;
      indicator_pkg::ST_NORMAL: text = indicator_pkg::TXT_FIELD_PAIR;
      indicator_pkg::ST_MSG:    text = indicator_pkg::TXT_MESSAGE;
      indicator_pkg::ST_WAIT:   text = indicator_pkg::TXT_SETUP_WAIT;
      indicator_pkg::ST_LOAD:   text = indicator_pkg::TXT_DOWNLOAD;
      indicator_pkg::ST_PING:   text = (step == 4'h0) ? indicator_pkg::TXT_PING
                                                      : indicator_pkg::TXT_DEVICE_NAME;
      default:                  text = indicator_pkg::TXT_BLANK;
    endcase
  end

  // ----------------------------------------------------------------------
  // registers and interrupt
  // ----------------------------------------------------------------------
  logic [1:0]             ctrl;
  logic [1:0]             next_ctrl;
  logic [`CFG_IRQ_W-1:0]  irq_stat;
  logic [`CFG_IRQ_W-1:0]  next_irq_stat;
  logic [`CFG_IRQ_W-1:0]  irq_mask;
  logic [`CFG_IRQ_W-1:0]  next_irq_mask;
  logic [`CFG_IRQ_W-1:0]  events;
  logic                   ack;
  logic                   next_ack;
  logic [31:0]            next_readdata;
  logic                   wr_now;

  always_comb begin
    events = '0;
    events[`CFG_IRQ_ERR]     = err_in.valid && !err_lock;
    events[`CFG_IRQ_AUTOCLR] = auto_clear;
    events[`CFG_IRQ_PING]    = ping_seen;
    events[`CFG_IRQ_LOADED]  = loaded_evt;
    // one wait cycle per access keeps read data registered
    next_ack      = (read || write) && !ack;
    wr_now        = write && ack;
    next_ctrl     = ctrl;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (wr_now && address == `CFG_REG_CTRL) begin
      next_ctrl = writedata[1:0];
    end
    if (wr_now && address == `CFG_REG_IRQ_MASK) begin
      next_irq_mask = writedata[`CFG_IRQ_W-1:0];
    end
    if (wr_now && address == `CFG_REG_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~writedata[`CFG_IRQ_W-1:0];
    end
    // a set in the clearing cycle wins
    next_irq_stat = next_irq_stat | events;
    next_readdata = readdata;
    if (read && !ack) begin
      case (address)
        `CFG_REG_CTRL:     next_readdata = {30'h0000_0000, ctrl};
        `CFG_REG_STATE:    next_readdata = {err_active, err_lock, 2'h0, err_code,
                                            err_letter, 4'h0, 4'(state)};
        `CFG_REG_IRQ_STAT: next_readdata = {28'h000_0000, irq_stat};
        `CFG_REG_IRQ_MASK: next_readdata = {28'h000_0000, irq_mask};
        default:           next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl     <= `CFG_CTRL_RESET;
      irq_stat <= '0;
      irq_mask <= `CFG_MASK_RESET;
      ack      <= 1'b0;
      readdata <= 32'h0000_0000;
    end else begin
      ctrl     <= next_ctrl;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      ack      <= next_ack;
      readdata <= next_readdata;
    end
  end

  assign waitrequest = (read || write) && !ack;
  assign irq         = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------------
  // LED and display outputs
  // ----------------------------------------------------------------------
  indicator_pkg::led_type     next_leds;
  indicator_pkg::display_type next_display;
  logic                       quad;

  always_comb begin
    quad      = ctrl[`CFG_CTRL_QUAD];
    next_leds = '0;
    if (scan.powered) begin
      if (err_active) begin
        next_leds.led1_red = flash;
      end else if (scan.safety_output_pair_on) begin
        next_leds.led1_green = 1'b1;
      end else begin
        next_leds.led1_red = 1'b1;
      end
      if (scan.protect_occupied) begin
        next_leds.led2 = flash;
      end else if (scan.restart_interlock_on && scan.restart_interlock_ready) begin
        next_leds.led2 = 1'b1;
      end else if (scan.linked_enabled) begin
        next_leds.led2 = 1'b1;
      end
      next_leds.led3     = scan.warn_occupied;
      next_leds.led6_red = err_active && flash;
      next_leds.led4     = quad && scan.warn3_occupied;
      next_leds.led5     = quad && scan.warn2_occupied && flash;
    end
    next_display.enabled     = ctrl[`CFG_CTRL_DISP_ON] && scan.powered;
    next_display.text        = text;
    next_display.from_device = err_src;
    next_display.letter      = (state == indicator_pkg::ST_MSG) ? err_letter : 8'h00;
    next_display.code        = (state == indicator_pkg::ST_MSG) ? err_code : 12'h000;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      leds    <= '0;
      display <= '0;
    end else begin
      leds    <= next_leds;
      display <= next_display;
    end
  end

endmodule // status_indicator

// [sim/status_indicator_chk.sv]
/*
  Port checker for status_indicator: bus timing, LED and message relations.
  Assumes it is bound to every status_indicator instance from this file.
*/
`timescale 1ns/1ps
module status_indicator_chk #(
  parameter int unsigned HALF_SEC_CYC = 4
) (
  input wire logic                          clock,
  input wire logic                          rst_b,
  input wire indicator_pkg::scan_state_type scan,
  input wire indicator_pkg::error_in_type   err_in,
  input wire logic [3:0]                    address,
  input wire logic                          read,
  input wire logic                          write,
  input wire logic [31:0]                   writedata,
  input wire logic [31:0]                   readdata,
  input wire logic                          waitrequest,
  input wire indicator_pkg::led_type        leds,
  input wire indicator_pkg::display_type    display,
  input wire logic                          irq
);
  // ----
  // locking error tracker
  // ----
  logic locked;
  logic next_locked;
  always_comb next_locked = locked | (err_in.valid & err_in.locking);
  always_ff @(posedge clock) locked <= rst_b ? next_locked : 1'b0;

  default clocking dc @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence acc_s;
    waitrequest ##1 !waitrequest;
  endsequence
  sequence err_s;
    err_in.valid && !locked;
  endsequence

  a_bus_two_cycle: assert property ($rose(read | write) |-> acc_s)
    else $error("access did not take two cycles");
  a_idle_no_wait: assert property (!(read | write) |-> !waitrequest)
    else $error("waitrequest without a request");
  a_read_hold: assert property (!read |=> $stable(readdata))
    else $error("readdata moved without a read");
  a_dark_unpowered: assert property ($past(!scan.powered) |-> !leds.led1_red && !leds.led1_green)
    else $error("led1 lit while unpowered");
  a_warn_led3: assert property ($past(scan.powered) && $past(rst_b)
    |-> leds.led3 == $past(scan.warn_occupied))
    else $error("led3 does not follow warning field");
  a_msg_code: assert property (err_s |-> ##3 display.text == indicator_pkg::TXT_MESSAGE
    && display.code == $past(err_in.code, 3)) else $error("error message not shown");
  a_lock_no_green: assert property (locked && $past(locked, 2) |-> !leds.led1_green)
    else $error("green while locked");
  a_lock_msg_hold: assert property (locked && $past(locked, 4)
    |-> display.text == indicator_pkg::TXT_MESSAGE) else $error("locked message left");
endmodule // status_indicator_chk

bind status_indicator status_indicator_chk #(.HALF_SEC_CYC(HALF_SEC_CYC)) chk (
  .clock(clock), .rst_b(rst_b), .scan(scan), .err_in(err_in), .address(address),
  .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .leds(leds), .display(display), .irq(irq));

// [sim/status_indicator_bench.sv]
/*
  Self-checking bench for status_indicator, driving every port directly.
  Assumes the checker is bound from its own file; half second is 4 cycles.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (a), (b)); end end
module status_indicator_bench;
  logic                          clock = 0;
  logic                          rst_b = 0;
  indicator_pkg::scan_state_type scan = '0;
  indicator_pkg::error_in_type   err_in = '0;
  logic [3:0]                    address = '0;
  logic                          read = 0;
  logic                          write = 0;
  logic [31:0]                   writedata = '0;
  logic [31:0]                   readdata;
  logic                          waitrequest;
  indicator_pkg::led_type        leds;
  indicator_pkg::display_type    display;
  logic                          irq;
  logic [31:0]                   rd;
  logic [7:0]                    lt [5] = '{8'h46, 8'h45, 8'h55, 8'h49, 8'h50};
  int                            error_cnt = 0;
  int                            n_checks = 0;
  always #12.5 clock = ~clock;
  status_indicator #(.HALF_SEC_CYC(4)) uut (.clock(clock), .rst_b(rst_b), .scan(scan),
    .err_in(err_in), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .leds(leds), .display(display), .irq(irq));
  // ----
  // tasks
  // ----
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // extra edge first so a strobe is never lowered and raised in one step
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    address <= a; writedata <= d; read <= !wr; write <= wr;
    i = 0;
    do begin @(posedge clock); i++; end while (waitrequest !== 1'b0 && i < 20);
    rd = readdata;
    read <= 0; write <= 0;
    if (i >= 20) begin error_cnt++; results(); end
  endtask
  task automatic err(input logic l, input logic dv, input int c, input logic [11:0] cd);
    err_in <= '{1'b1, l, dv, indicator_pkg::category_type'(c), cd};
    @(posedge clock);
    err_in.valid <= 0;
  endtask
  // a flashing led must show both levels within ten cycles, a flash period and a quarter
  task automatic flash(input int b);
    int ones;
    ones = 0;
    repeat (10) begin @(posedge clock); ones += leds[b]; end
    `CHK(ones > 0 && ones < 10, 1'b1)
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    scan.powered <= 1;
    cyc(3); rst_b <= 1;
    cyc(2); `CHK(display.text, indicator_pkg::TXT_TYPE)
    cyc(100); `CHK(display.text, indicator_pkg::TXT_SETUP_REQUIRED)
    scan.boot_done <= 1;
    cyc(3); `CHK(display.text, indicator_pkg::TXT_LEVEL)
    bus(0, 4'h4, 0); `CHK(rd[3:0], 4'h1)
    bus(0, 4'h0, 0); `CHK(rd, 32'h0000_0001)
    bus(0, 4'hC, 0); `CHK(rd, 32'h0000_0000)
    bus(1, 4'h2, 32'hFFFF_FFFF); bus(0, 4'h2, 0); `CHK(rd, 32'h0000_0000)
    $display("test unconfigured boot done");
    rst_b <= 0; scan.has_config <= 1; scan.boot_done <= 0;
    cyc(3); rst_b <= 1;
    cyc(120); `CHK(display.text, indicator_pkg::TXT_SIGNATURE)
    cyc(10); `CHK(display.text, indicator_pkg::TXT_LEVEL)
    scan.boot_done <= 1;
    cyc(3); `CHK(display.text, indicator_pkg::TXT_FIELD_PAIR)
    `CHK(display.enabled, 1'b1)
    $display("test configured boot done");
    scan.powered <= 0; scan.warn_occupied <= 1;
    cyc(3); `CHK(leds, 7'h00)
    `CHK(display.enabled, 1'b0)
    scan.powered <= 1; scan.safety_output_pair_on <= 1;
    cyc(3); `CHK(leds.led1_green, 1'b1)
    `CHK(leds.led3, 1'b1)
    scan.safety_output_pair_on <= 0; scan.warn_occupied <= 0;
    cyc(3); `CHK(leds.led1_red, 1'b1)
    `CHK(leds.led3, 1'b0)
    scan.warn3_occupied <= 1; scan.warn2_occupied <= 1;
    bus(1, 4'h0, 32'h0000_0000);
    cyc(2); `CHK(leds.led4, 1'b0)
    `CHK(leds.led5, 1'b0)
    `CHK(display.enabled, 1'b0)
    bus(1, 4'h0, 32'h0000_0003);
    cyc(3); `CHK(leds.led4, 1'b1)
    flash(1);
    scan.protect_occupied <= 1;
    flash(4);
    scan.protect_occupied <= 0; scan.restart_interlock_on <= 1;
    scan.restart_interlock_ready <= 1;
    cyc(3); `CHK(leds.led2, 1'b1)
    scan.restart_interlock_on <= 0; scan.linked_enabled <= 1;
    cyc(3); `CHK(leds.led2, 1'b1)
    $display("test leds done");
    bus(1, 4'hC, 32'h0000_000F);
    scan.ping <= 1; cyc(1); scan.ping <= 0;
    cyc(4); `CHK(display.text, indicator_pkg::TXT_PING)
    cyc(16); `CHK(display.text, indicator_pkg::TXT_DEVICE_NAME)
    `CHK(irq, 1'b1)
    bus(0, 4'h8, 0); `CHK(rd[2], 1'b1)
    bus(1, 4'h8, 32'h0000_000F);
    cyc(2); `CHK(irq, 1'b0)
    scan.setup_wait <= 1; cyc(1); scan.setup_wait <= 0;
    cyc(3); `CHK(display.text, indicator_pkg::TXT_SETUP_WAIT)
    scan.setup_confirmed <= 1; cyc(1); scan.setup_confirmed <= 0;
    cyc(3); `CHK(display.text, indicator_pkg::TXT_DOWNLOAD)
    scan.setup_done <= 1; cyc(1); scan.setup_done <= 0;
    cyc(3); `CHK(display.text, indicator_pkg::TXT_FIELD_PAIR)
    bus(0, 4'h8, 0); `CHK(rd[3], 1'b1)
    bus(1, 4'h8, 32'h0000_000F);
    $display("test ping and setup done");
    for (int c = 0; c < 5; c++) begin
      err(0, 0, c, 12'h100 + 12'(c));
      cyc(4); `CHK(display.letter, lt[c])
      `CHK(display.code, 12'h100 + 12'(c))
    end
    scan.protect_occupied <= 1;
    cyc(40); err(0, 1, 1, 12'h123);
    cyc(4); `CHK(display.from_device, 1'b1)
    `CHK(irq, 1'b1)
    cyc(66); bus(0, 4'h4, 0); `CHK(rd[31], 1'b1)
    cyc(20); bus(0, 4'h4, 0); `CHK(rd[31], 1'b0)
    bus(0, 4'h8, 0); `CHK(rd[1:0], 2'h3)
    `CHK(leds.led1_green, 1'b0)
    `CHK(display.text, indicator_pkg::TXT_MESSAGE)
    scan.protect_occupied <= 0;
    cyc(30); `CHK(display.text, indicator_pkg::TXT_MESSAGE)
    cyc(20); `CHK(display.text, indicator_pkg::TXT_FIELD_PAIR)
    $display("test timed clearing done");
    bus(1, 4'h8, 32'h0000_000F); bus(1, 4'hC, 32'h0000_0000);
    err(1, 1, 0, 12'h0AB);
    cyc(4); `CHK(display.letter, 8'h46)
    flash(6);
    flash(0);
    `CHK(irq, 1'b0)
    bus(1, 4'hC, 32'h0000_0001); cyc(1); `CHK(irq, 1'b1)
    err(0, 0, 1, 12'h0CD);
    cyc(4); `CHK(display.code, 12'h0AB)
    cyc(120); bus(0, 4'h4, 0); `CHK(rd[31:30], 2'h3)
    rst_b <= 0; cyc(3); rst_b <= 1;
    bus(0, 4'h4, 0); `CHK(rd[31], 1'b0)
    $display("test locking error done");
    results();
  end
endmodule // status_indicator_bench
